// ---- logic/tfs_ctrl.sv ----
// Framing select control for four T1/J1 channels, reached over APB.
// Assumes the framer supplies superframe boundary strobes, signaling
// words, the CRC bit stream and sync candidate counts on mclk.
`timescale 1ns/10ps
`include "tfs_defines.svh"

module tfs_ctrl
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [`TFS_CH-1:0] rx_sf_boundary,
   input wire logic [`TFS_CH-1:0] rx_sig_valid,
   output logic [`TFS_CH-1:0] rx_sig_ready,
   input wire logic [`TFS_CH-1:0][4:0] rx_sig_slot,
   input wire logic [`TFS_CH-1:0][3:0] rx_sig_data,
   output logic [`TFS_CH-1:0] receive_signaling_output_valid,
   output logic [`TFS_CH-1:0][4:0] receive_signaling_output_slot,
   output logic [`TFS_CH-1:0][3:0] receive_signaling_output,
   input wire logic [`TFS_CH-1:0] tx_sf_boundary,
   input wire logic [`TFS_CH-1:0][`TFS_SLOTS-1:0][3:0] tx_sig_in,
   output logic [`TFS_CH-1:0][`TFS_SLOTS-1:0][3:0] tx_sig_out,
   input wire logic [`TFS_CH-1:0] mf_start,
   input wire logic [`TFS_CH-1:0] crc_bit_valid,
   input wire logic [`TFS_CH-1:0] crc_bit,
   input wire logic [`TFS_CH-1:0] crc_bit_is_fe,
   output logic [`TFS_CH-1:0] crc_word_valid,
   output logic [`TFS_CH-1:0][5:0] crc_word,
   output tfs_pkg::tfs_yfmt_t [`TFS_CH-1:0] yellow_fmt,
   output logic [`TFS_CH-1:0] japan_variant_select,
   input wire logic [`TFS_CH-1:0] sync_window_end,
   input wire logic [`TFS_CH-1:0][3:0] sync_cand_count,
   output logic [`TFS_CH-1:0] sync_found
);

   // ***********************************************************
   // Decoding
   // ***********************************************************
   // The channel number sits above the twelve-bit register index, so every
   // channel sees the same map; the two low byte address bits are ignored.
   function automatic tfs_pkg::tfs_dec_t tfs_decode(input logic [15:0] a);
      tfs_pkg::tfs_dec_t r;
      logic [13:0] idx;
      r = '0;
      idx = a[15:2];
      r.ch = idx[13:12];
      r.slot = 5'(idx[11:0] - `TFS_RSA_LO);
      if (idx[11:0] == `TFS_FSC_IDX)
      begin
         r.hit = 1'b1;
      end
      else if (idx[11:0] >= `TFS_RSA_LO && idx[11:0] <= `TFS_RSA_HI)
      begin
         r.hit = 1'b1;
         r.rsa = 1'b1;
      end
      return r;
   endfunction

   function automatic tfs_pkg::tfs_yfmt_t tfs_fmt(input logic [7:0] f);
      tfs_pkg::tfs_yfmt_t r;
      if (f[`TFS_J1_BIT])
      begin
         r = f[`TFS_FSI_MSB] ? tfs_pkg::J1_SF : tfs_pkg::J1_ESF;
      end
      else
      begin
         r = f[`TFS_FSI_MSB] ? tfs_pkg::T1_SF : tfs_pkg::T1_ESF;
      end
      return r;
   endfunction

   tfs_pkg::tfs_state_t q, d;
   tfs_pkg::tfs_dec_t dec;
   logic [`TFS_CH-1:0] f_valid;
   logic [`TFS_CH-1:0] f_pop;
   logic [`TFS_CH-1:0][`TFS_FIFO_WIDTH-1:0] f_data;

   assign dec = tfs_decode(paddr);
   assign pready = psel && penable;
   assign prdata = q.prdata;
   assign pslverr = pready && q.slverr;

   // ***********************************************************
   // Receive signaling buffers
   // ***********************************************************
   // A full buffer stalls the framer through rx_sig_ready, which is why
   // holding updates for a whole superframe cannot drop words.
   genvar gc;
   generate
      for (gc = 0; gc < `TFS_CH; gc++)
      begin : g_ch
         tfs_fifo #(.WIDTH(`TFS_FIFO_WIDTH), .DEPTH(`TFS_FIFO_DEPTH)) u_fifo
         (
            .mclk(mclk),
            .rst(rst),
            .in_valid(rx_sig_valid[gc]),
            .in_ready(rx_sig_ready[gc]),
            .in_data({rx_sig_slot[gc], rx_sig_data[gc]}),
            .out_valid(f_valid[gc]),
            .out_ready(f_pop[gc]),
            .out_data(f_data[gc])
         );
         assign f_pop[gc] = f_valid[gc]
            && (!q.fsc[gc][`TFS_SF_UPD_BIT] || q.rel[gc]);

         AST_RX_HOLD: assert property (@(posedge mclk)
            disable iff (rst)
            q.fsc[gc][`TFS_SF_UPD_BIT] && !q.rel[gc]
            |=> !receive_signaling_output_valid[gc])
            else $error("Receive signaling updated before boundary.");
         AST_RX_NOW: assert property (@(posedge mclk)
            disable iff (rst)
            !q.fsc[gc][`TFS_SF_UPD_BIT] && f_valid[gc]
            |=> receive_signaling_output_valid[gc])
            else $error("Receive signaling not updated at once.");
         AST_TX_HOLD: assert property (@(posedge mclk)
            disable iff (rst)
            q.fsc[gc][`TFS_SF_UPD_BIT] && !tx_sf_boundary[gc]
            |=> $stable(tx_sig_out[gc]))
            else $error("Transmit signaling changed off boundary.");
         AST_TX_NOW: assert property (@(posedge mclk)
            disable iff (rst)
            !q.fsc[gc][`TFS_SF_UPD_BIT]
            |=> tx_sig_out[gc] == $past(tx_sig_in[gc]))
            else $error("Transmit signaling not sent at once.");
         AST_CRC_FORCE: assert property (@(posedge mclk)
            disable iff (rst)
            crc_word_valid[gc] |-> (crc_word[gc] ^ q.crcr[gc])
            == ($past(q.fsc[gc][`TFS_FORCE_CRC_BIT]) ? `TFS_CRC_BAD : 6'h00))
            else $error("CRC word corruption does not follow force bit.");
         AST_MF_LEN: assert property (@(posedge mclk)
            disable iff (rst)
            crc_bit_valid[gc] && !mf_start[gc]
            && q.bcnt[gc] == `TFS_MF_BITS - 13'd1 |=> crc_word_valid[gc])
            else $error("CRC word not closed after a full multiframe.");
         AST_YEL_J1: assert property (@(posedge mclk)
            disable iff (rst)
            q.fsc[gc][`TFS_J1_BIT] |=> yellow_fmt[gc] inside
            {tfs_pkg::J1_SF, tfs_pkg::J1_ESF})
            else $error("Japan_variant_select without J1 yellow alarm format.");
         AST_FMT_SEL: assert property (@(posedge mclk)
            disable iff (rst)
            ##1 yellow_fmt[gc] == tfs_fmt($past(q.fsc[gc])))
            else $error("Superframe format does not follow register.");
         AST_SYNC_ANY: assert property (@(posedge mclk)
            disable iff (rst)
            sync_window_end[gc] && !q.fsc[gc][`TFS_ONE_BIT]
            && sync_cand_count[gc] != 4'h0 |=> sync_found[gc])
            else $error("Valid candidate rejected.");
         AST_SYNC_ONE: assert property (@(posedge mclk)
            disable iff (rst)
            sync_window_end[gc] && q.fsc[gc][`TFS_ONE_BIT]
            && sync_cand_count[gc] != 4'h1 |=> !sync_found[gc])
            else $error("Sync declared without a single candidate.");
         AST_CH_ISO: assert property (@(posedge mclk)
            disable iff (rst)
            pready && pwrite && dec.ch != 2'(gc) |=> $stable(q.fsc[gc]))
            else $error("Write reached another channel's register.");
         AST_CH_OWN: assert property (@(posedge mclk)
            disable iff (rst)
            pready && pwrite && dec.hit && !dec.rsa && dec.ch == 2'(gc)
            |=> q.fsc[gc] == $past(pwdata[7:0]))
            else $error("Write missed its own channel's register.");
      end
   endgenerate

   // ***********************************************************
   // Next state
   // ***********************************************************
   always_comb
   begin
      logic [5:0] nx;
      logic b;
      logic [4:0] slot;
      nx = '0;
      b = 1'b0;
      slot = '0;
      d = q;
      for (int c = 0; c < `TFS_CH; c++)
      begin
         d.rso_v[c] = 1'b0;
         slot = f_data[c][8:4];
         if (f_pop[c])
         begin
            if (slot < 5'(`TFS_SLOTS))
            begin
               d.rsa[c][slot] = f_data[c][3:0];
            end
            d.rso_v[c] = 1'b1;
            d.rso_slot[c] = slot;
            d.rso_data[c] = f_data[c][3:0];
         end
         // Release lasts until the buffer is empty; a boundary wins over
         // the clear so that a superframe is never skipped.
         if (rx_sf_boundary[c])
         begin
            d.rel[c] = 1'b1;
         end
         else if (!f_valid[c])
         begin
            d.rel[c] = 1'b0;
         end
         if (!q.fsc[c][`TFS_SF_UPD_BIT] || tx_sf_boundary[c])
         begin
            d.txs[c] = tx_sig_in[c];
         end
         d.crcw_v[c] = 1'b0;
         if (mf_start[c])
         begin
            d.crc[c] = '0;
            d.bcnt[c] = '0;
         end
         else if (crc_bit_valid[c])
         begin
            b = (crc_bit_is_fe[c] && !q.fsc[c][`TFS_J1_BIT])
               ? 1'b1 : crc_bit[c];
            nx = {q.crc[c][4:0], 1'b0}
               ^ ((b ^ q.crc[c][5]) ? `TFS_CRC_POLY : 6'h00);
            if (q.bcnt[c] == `TFS_MF_BITS - 13'd1)
            begin
               d.crcr[c] = nx;
               d.crcw[c] = nx ^ (q.fsc[c][`TFS_FORCE_CRC_BIT]
                  ? `TFS_CRC_BAD : 6'h00);
               d.crcw_v[c] = 1'b1;
               d.crc[c] = '0;
               d.bcnt[c] = '0;
            end
            else
            begin
               d.crc[c] = nx;
               d.bcnt[c] = q.bcnt[c] + 13'd1;
            end
         end
         d.yfmt[c] = tfs_fmt(q.fsc[c]);
         d.sync[c] = 1'b0;
         if (sync_window_end[c])
         begin
            d.sync[c] = q.fsc[c][`TFS_ONE_BIT]
               ? (sync_cand_count[c] == 4'h1)
               : (sync_cand_count[c] != 4'h0);
         end
      end
      // Read data are captured in the setup cycle, so the access cycle
      // completes at once with data from a flip-flop.
      if (psel && !penable)
      begin
         d.prdata = '0;
         d.slverr = !dec.hit || (dec.rsa && pwrite);
         if (dec.hit && dec.rsa)
         begin
            d.prdata = {28'h0, q.rsa[dec.ch][dec.slot]};
         end
         else if (dec.hit)
         begin
            d.prdata = {24'h0, q.fsc[dec.ch]};
         end
      end
      if (pready && pwrite && dec.hit && !dec.rsa)
      begin
         d.fsc[dec.ch] = pwdata[7:0];
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         q <= '0;
         q.fsc <= {`TFS_CH{`TFS_FSC_RST}};
      end
      else
      begin
         q <= d;
      end
   end

   // ***********************************************************
   // Outputs
   // ***********************************************************
   assign receive_signaling_output_valid = q.rso_v;
   assign receive_signaling_output_slot = q.rso_slot;
   assign receive_signaling_output = q.rso_data;
   assign tx_sig_out = q.txs;
   assign crc_word_valid = q.crcw_v;
   assign crc_word = q.crcw;
   assign yellow_fmt = q.yfmt;
   assign sync_found = q.sync;

   generate
      for (gc = 0; gc < `TFS_CH; gc++)
      begin : g_j1
         assign japan_variant_select[gc] = q.fsc[gc][`TFS_J1_BIT];
      end
   endgenerate

endmodule

// ---- logic/tfs_defines.svh ----
// Constants of the per-channel framing select control block.
// Assumes inclusion by bare name from the package and the main module.
`ifndef TFS_DEFINES_SVH
`define TFS_DEFINES_SVH

`define TFS_CH 4
`define TFS_FSC_IDX 12'h107
`define TFS_RSA_LO 12'h120
`define TFS_RSA_HI 12'h137
`define TFS_FSC_RST 8'h00
`define TFS_SF_UPD_BIT 7
`define TFS_FORCE_CRC_BIT 6
`define TFS_J1_BIT 5
`define TFS_ONE_BIT 4
`define TFS_FSI_MSB 2
`define TFS_SLOTS 24
`define TFS_MF_BITS 13'd4632
`define TFS_CRC_POLY 6'h03
`define TFS_CRC_BAD 6'h3F
`define TFS_FIFO_DEPTH 16
`define TFS_FIFO_WIDTH 9

`endif

// ---- logic/tfs_fifo.sv ----
// First-in first-out buffer with valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps

module tfs_fifo
#(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
)
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);

   localparam int AW = $clog2(DEPTH);

   // ***********************************************************
   // State
   // ***********************************************************
   // The head word lives in its own register so read data come from a
   // flip-flop; the store behind it holds DEPTH more words.
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] cnt;
      logic [WIDTH-1:0] head;
      logic hv;
   } tfs_fifo_st_t;

   tfs_fifo_st_t q, d;
   logic push;
   logic pop;

   assign in_ready = (q.cnt != (AW + 1)'(DEPTH)) || !q.hv;
   assign out_valid = q.hv;
   assign out_data = q.head;
   assign push = in_valid && in_ready;
   assign pop = q.hv && out_ready;

   always_comb
   begin
      d = q;
      if (pop || !q.hv)
      begin
         if (q.cnt != '0)
         begin
            d.head = q.mem[q.rd];
            d.hv = 1'b1;
            d.rd = q.rd + 1'b1;
            d.cnt = q.cnt - 1'b1;
         end
         else
         begin
            d.hv = push;
            d.head = in_data;
         end
      end
      if (push && (q.cnt != '0 || (q.hv && !pop)))
      begin
         d.mem[q.wr] = in_data;
         d.wr = q.wr + 1'b1;
         d.cnt = d.cnt + 1'b1;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

endmodule

// ---- logic/tfs_pkg.sv ----
// Types shared by the framing select control block.
// Assumes the constants header sits in the include path.
`include "tfs_defines.svh"

package tfs_pkg;

   typedef enum logic [1:0] {
      T1_ESF,
      T1_SF,
      J1_ESF,
      J1_SF
   } tfs_yfmt_t;

   typedef struct packed {
      logic hit;
      logic rsa;
      logic [1:0] ch;
      logic [4:0] slot;
   } tfs_dec_t;

   typedef struct packed {
      logic [`TFS_CH-1:0][7:0] fsc;
      logic [`TFS_CH-1:0][`TFS_SLOTS-1:0][3:0] rsa;
      logic [`TFS_CH-1:0] rel;
      logic [`TFS_CH-1:0] rso_v;
      logic [`TFS_CH-1:0][4:0] rso_slot;
      logic [`TFS_CH-1:0][3:0] rso_data;
      logic [`TFS_CH-1:0][`TFS_SLOTS-1:0][3:0] txs;
      logic [`TFS_CH-1:0][5:0] crc;
      logic [`TFS_CH-1:0][12:0] bcnt;
      logic [`TFS_CH-1:0][5:0] crcw;
      logic [`TFS_CH-1:0][5:0] crcr;
      logic [`TFS_CH-1:0] crcw_v;
      tfs_yfmt_t [`TFS_CH-1:0] yfmt;
      logic [`TFS_CH-1:0] sync;
      logic [31:0] prdata;
      logic slverr;
   } tfs_state_t;

endpackage

// ---- test/tb_t1_framing_select_control.sv ----
// Self-checking bench of the framing select control over APB.
// Assumes the line model drives the framer side of channel 0.
`timescale 1ns/10ps

module tb_t1_framing_select_control;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [15:0] paddr = 16'h0000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rd;
   logic pready, pslverr, er;
   logic [3:0] rx_sf_boundary, rx_sig_valid, rx_sig_ready, tx_sf_boundary;
   logic [3:0][4:0] rx_sig_slot, receive_signaling_output_slot;
   logic [3:0][3:0] rx_sig_data, receive_signaling_output, sync_cand_count;
   logic [3:0] receive_signaling_output_valid, mf_start, crc_bit_valid;
   logic [3:0] crc_bit, crc_bit_is_fe, crc_word_valid, sync_window_end;
   logic [3:0] japan_variant_select, sync_found;
   logic [3:0][23:0][3:0] tx_sig_in = '0;
   logic [3:0][23:0][3:0] tx_sig_out;
   logic [3:0][5:0] crc_word;
   tfs_pkg::tfs_yfmt_t [3:0] yellow_fmt;
   int err_total = 0;
   int checks_done = 0;
   int pulses = 0;
   int base, n, w;

   tfs_ctrl tfs_ctrl_i (.mclk, .rst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .rx_sf_boundary, .rx_sig_valid,
      .rx_sig_ready, .rx_sig_slot, .rx_sig_data,
      .receive_signaling_output_valid, .receive_signaling_output_slot,
      .receive_signaling_output, .tx_sf_boundary, .tx_sig_in, .tx_sig_out,
      .mf_start, .crc_bit_valid, .crc_bit, .crc_bit_is_fe, .crc_word_valid,
      .crc_word, .yellow_fmt, .japan_variant_select, .sync_window_end,
      .sync_cand_count, .sync_found);
   tfs_line_model tfs_line_model_i (.mclk, .rx_sig_ready, .rx_sf_boundary,
      .rx_sig_valid, .rx_sig_slot, .rx_sig_data, .tx_sf_boundary, .mf_start,
      .crc_bit_valid, .crc_bit, .crc_bit_is_fe, .sync_window_end,
      .sync_cand_count);

   // ************************************************************
   // Helpers
   // ************************************************************
   always #20 mclk = ~mclk;

   always @(posedge mclk)
   begin
      if (receive_signaling_output_valid[0] === 1'b1)
         pulses <= pulses + 1;
   end

   function automatic logic [15:0] ctl(input int c);
      return 16'((32'h107 + 32'h1000 * c) * 4);
   endfunction

   function automatic logic [15:0] arr(input int s);
      return 16'((32'h120 + s) * 4);
   endfunction

   function automatic logic [5:0] crc_ref(input logic j1);
      logic [5:0] c;
      logic b;
      c = 6'h00;
      for (int i = 0; i < 4632; i++)
      begin
         b = (i % 772 == 0) ? !j1 : (i[0] ^ i[2] ^ i[5]);
         c = {c[4:0], 1'b0} ^ ((c[5] ^ b) ? 6'h03 : 6'h00);
      end
      return c;
   endfunction

   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] x,
      input string m);
      checks_done++;
      if (g !== x)
      begin
         err_total++;
         $display("ERROR %0t: %0s got %h want %h", $time, m, g, x);
      end
   endtask

   task automatic hang(input string m);
      err_total++;
      $display("ERROR %0t: timeout %0s", $time, m);
      conclude();
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge mclk);
   endtask

   task automatic apb(input logic wr, input logic [15:0] a,
      input logic [31:0] d);
      int k;
      k = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do
      begin
         @(posedge mclk);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      if (k >= 20)
         hang("pready");
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial
   begin
      cyc(10);
      rst <= 1'b0;
      cyc(1);
      for (int c = 0; c < 4; c++)
      begin
         apb(1'b0, ctl(c), 32'h0);
         chk(rd, 32'h0, "reset value");
      end
      apb(1'b0, 16'h0418, 32'h0);
      chk({31'h0, er}, 32'h1, "unmapped error");
      chk(rd, 32'h0, "unmapped data");
      apb(1'b1, arr(6), 32'h0000_000F);
      chk({31'h0, er}, 32'h1, "array write");
      apb(1'b1, ctl(2), 32'h0000_002D);
      for (int c = 0; c < 4; c++)
      begin
         apb(1'b0, ctl(c), 32'h0);
         chk(rd, (c == 2) ? 32'h2D : 32'h0, "channel copy");
      end
      cyc(1);
      chk(32'(japan_variant_select), 32'h4, "j1 per channel");
      for (int k = 0; k < 4; k++)
      begin
         apb(1'b1, ctl(0), {26'h0, k[1], 2'b00, k[0], 2'b00});
         cyc(1);
         chk(32'(yellow_fmt[0]), 32'(k), "yellow format");
      end
      $display("test registers done");
      for (int k = 0; k < 6; k++)
      begin
         apb(1'b1, ctl(0), (k < 3) ? 32'h0 : 32'h10);
         tfs_line_model_i.sync(4'(k % 3));
         @(posedge mclk);
         chk(32'(sync_found[0]), (k < 3) ? 32'(k % 3 != 0) :
            32'(k % 3 == 1), "sync");
      end
      $display("test sync done");
      for (int k = 0; k < 3; k++)
      begin
         apb(1'b1, ctl(0), (k == 0) ? 32'h0 : ((k == 1) ? 32'h20 : 32'h40));
         tfs_line_model_i.run_mf();
         w = 0;
         while (crc_word_valid[0] !== 1'b1 && w < 5)
         begin
            @(posedge mclk);
            w++;
         end
         if (w >= 5)
            hang("crc word");
         chk(32'(crc_word[0]), {26'h0, (k == 2) ? ~crc_ref(1'b0) :
            crc_ref(k == 1)}, "crc word");
      end
      $display("test crc done");
      apb(1'b1, ctl(0), 32'h0);
      tx_sig_in[0][3] <= 4'hA;
      cyc(2);
      chk(32'(tx_sig_out[0][3]), 32'hA, "tx at once");
      apb(1'b1, ctl(0), 32'h80);
      tx_sig_in[0][3] <= 4'h5;
      cyc(3);
      chk(32'(tx_sig_out[0][3]), 32'hA, "tx held");
      tfs_line_model_i.bound(1'b0);
      @(posedge mclk);
      chk(32'(tx_sig_out[0][3]), 32'h5, "tx at boundary");
      $display("test transmit done");
      apb(1'b1, ctl(0), 32'h0);
      base = pulses;
      tfs_line_model_i.fill(1, n);
      w = 0;
      while (pulses == base && w < 8)
      begin
         @(posedge mclk);
         w++;
      end
      if (w >= 8)
         hang("rx pulse");
      chk(32'(receive_signaling_output_slot[0]), 32'h5, "rx slot");
      chk(32'(receive_signaling_output[0]), 32'h9, "rx data");
      apb(1'b0, arr(5), 32'h0);
      chk(rd, 32'h9, "array now");
      apb(1'b1, ctl(0), 32'h80);
      base = pulses;
      tfs_line_model_i.fill(20, n);
      chk(32'(n), 32'd17, "buffer refuses when full");
      chk(32'(pulses - base), 32'h0, "rx held");
      apb(1'b0, arr(6), 32'h0);
      chk(rd, 32'h0, "array held");
      tfs_line_model_i.bound(1'b1);
      cyc(40);
      chk(32'(pulses - base), 32'd17, "rx at boundary");
      apb(1'b0, arr(6), 32'h0);
      chk(rd, 32'hA, "array at boundary");
      $display("test receive done");
      conclude();
   end
endmodule

// ---- test/tfs_line_model.sv ----
// Line side model: receive signaling, boundaries, CRC bit stream, sync.
// Assumes its tasks are called just after a rising mclk edge.
`timescale 1ns/10ps

module tfs_line_model
(
   input wire logic mclk,
   input wire logic [3:0] rx_sig_ready,
   output logic [3:0] rx_sf_boundary,
   output logic [3:0] rx_sig_valid,
   output logic [3:0][4:0] rx_sig_slot,
   output logic [3:0][3:0] rx_sig_data,
   output logic [3:0] tx_sf_boundary,
   output logic [3:0] mf_start,
   output logic [3:0] crc_bit_valid,
   output logic [3:0] crc_bit,
   output logic [3:0] crc_bit_is_fe,
   output logic [3:0] sync_window_end,
   output logic [3:0][3:0] sync_cand_count
);
   // ************************************************************
   // Stimulus tasks
   // ************************************************************
   initial
   begin
      rx_sf_boundary = '0;
      rx_sig_valid = '0;
      rx_sig_slot = '0;
      rx_sig_data = '0;
      tx_sf_boundary = '0;
      mf_start = '0;
      crc_bit_valid = '0;
      crc_bit = '0;
      crc_bit_is_fe = '0;
      sync_window_end = '0;
      sync_cand_count = '0;
   end

   task automatic bound(input logic rx);
      if (rx)
         rx_sf_boundary[0] <= 1'b1;
      else
         tx_sf_boundary[0] <= 1'b1;
      @(posedge mclk);
      rx_sf_boundary[0] <= 1'b0;
      tx_sf_boundary[0] <= 1'b0;
   endtask

   // Words are held until accepted, so a full buffer stalls the stream.
   task automatic fill(input int want, output int got);
      int n;
      got = 0;
      n = 0;
      rx_sig_valid[0] <= 1'b1;
      rx_sig_slot[0] <= 5'h05;
      rx_sig_data[0] <= 4'h9;
      while (got < want && n < 60)
      begin
         @(posedge mclk);
         n++;
         if (rx_sig_ready[0] === 1'b1)
         begin
            got++;
            rx_sig_slot[0] <= 5'(5 + got);
            rx_sig_data[0] <= 4'(9 + got);
         end
      end
      rx_sig_valid[0] <= 1'b0;
   endtask

   // Extension bits are sent as zero so both CRC modes differ.
   task automatic run_mf();
      mf_start[0] <= 1'b1;
      @(posedge mclk);
      mf_start[0] <= 1'b0;
      crc_bit_valid[0] <= 1'b1;
      for (int i = 0; i < 4632; i++)
      begin
         crc_bit_is_fe[0] <= (i % 772 == 0);
         crc_bit[0] <= (i % 772 == 0) ? 1'b0 : (i[0] ^ i[2] ^ i[5]);
         @(posedge mclk);
      end
      crc_bit_valid[0] <= 1'b0;
      crc_bit[0] <= ~crc_bit[0];
   endtask

   task automatic sync(input logic [3:0] cnt);
      sync_cand_count[0] <= cnt;
      sync_window_end[0] <= 1'b1;
      @(posedge mclk);
      sync_window_end[0] <= 1'b0;
      sync_cand_count[0] <= ~cnt;
   endtask
endmodule
